// File: hdl/sptsb_slave.v
// Two-wire slave front end with thermal sensor registers and alarm output
// Functional notes
// - Match select bits against three address inputs
// - Unconnected select inputs read as zero
// - Bit0 high-voltage sense gates lock commands
// - Alarm has interrupt, comparator, critical-only modes
// - Latched alarm cleared by writing one
// - Comparator alarm clears when condition leaves
// - Critical comparison always acts as comparator
// - Critical-only holds until below limit minus hysteresis
// - Polarity and interrupt/comparator both configurable
// - Active-high alarm rests at zero
// - Lower memory half lockable, permanent or reversible
// - Temperature refreshed at least eight per second
// - Latest temperature held for reading anytime
// - Upper, lower, critical limits feed comparison
// - Slave only, never holds clock low
// - Type codes 1010 memory, 0110 lock, 0011 sensor
// - Device acknowledges each written byte ninth bit
// - Sensor pointer register selects accessed register
// - Sensor transfers two bytes, high first, MSB first
// - Select byte bit0 one reads, zero writes
// - Memory section releases bus on mismatch
//
// The register offsets and the APB slave port were decided locally.
`include "sptsb_map.vh"
module sptsb_slave #(
  parameter [31:0] SAMPLE_CYC = `SPTSB_SAMPLE_CYC
) (
  input  wire        clk,              // 50 MHz system clock
  input  wire        rst_n,            // Asynchronous reset, active low
  input  wire        scl_in,           // Serial clock level
  input  wire        sda_in,           // Serial data level
  output reg         sda_out,          // Serial data drive value, always low
  output reg         sda_oe,           // High while pulling data low
  output reg         scl_oe,           // Clock drive enable, never set
  input  wire        addr_select_bit0, // Select input 0, low if unconnected
  input  wire        addr_select_bit1, // Select input 1
  input  wire        addr_select_bit2, // Select input 2
  input  wire        high_voltage_level, // High-voltage sense on select input 0
  input  wire [15:0] temp_sample,      // Converter result
  output reg         alarm_out,        // Alarm pin drive value, always low
  output reg         alarm_oe,         // High while pulling alarm low
  output reg         lock_reversible,  // Reversible lower-half lock state
  output reg         lock_permanent,   // Permanent lower-half lock state
  output reg         mem_selected,     // Memory section addressed
  input  wire        psel,             // APB select
  input  wire        penable,          // APB enable
  input  wire        pwrite,           // APB direction
  input  wire [11:0] paddr,            // APB byte address
  input  wire [31:0] pwdata,           // APB write data
  output reg  [31:0] prdata,           // APB read data
  output reg         pready,           // APB ready
  output reg         pslverr           // APB error on unmapped address
);
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_ADDR = 3'd1;
  localparam [2:0] ST_WR   = 3'd2;
  localparam [2:0] ST_RD   = 3'd3;
  localparam [2:0] ST_ACK  = 3'd4;
  localparam [2:0] ST_MACK = 3'd5;
  localparam [2:0] ST_SKIP = 3'd6;

  reg [2:0]  state;
  reg [2:0]  ret_state;
  reg        scl_d;
  reg        sda_d;
  reg [7:0]  shreg;
  reg [3:0]  bitcnt;
  reg [1:0]  bytecnt;
  reg [3:0]  dtype;
  reg        is_read;
  reg [7:0]  pointer;
  reg [7:0]  alarm_cfg;
  reg [15:0] upper_lim;
  reg [15:0] lower_lim;
  reg [15:0] critical_temp_limit;
  reg [15:0] temp_held;
  reg [15:0] tx_word;
  reg [7:0]  wr_hi;
  reg [31:0] sample_cnt;
  reg        event_latched;
  reg        crit_hold;
  reg        drive_low;
  reg        clear_req;
  reg        next_alarm;
  reg [15:0] hyst;
  wire       scl_rise = scl_in & ~scl_d;
  wire       scl_fall = ~scl_in & scl_d;
  wire       start_c  = scl_in & scl_d & sda_d & ~sda_in;
  wire       stop_c   = scl_in & scl_d & ~sda_d & sda_in;
  wire [2:0] sel_pins = {addr_select_bit2, addr_select_bit1, addr_select_bit0};
  wire       apb_acc  = psel & penable & pready;

  always @* begin
    case (alarm_cfg[`SPTSB_CFG_HYST_HI:`SPTSB_CFG_HYST_LO])
      2'd0: hyst = `SPTSB_HYST_0;
      2'd1: hyst = `SPTSB_HYST_1;
      2'd2: hyst = `SPTSB_HYST_2;
      default: hyst = `SPTSB_HYST_3;
    endcase
  end

  wire above_upper = $signed(temp_held) > $signed(upper_lim);
  wire below_lower = $signed(temp_held) < $signed(lower_lim);
  wire above_crit  = $signed(temp_held) > $signed(critical_temp_limit);
  wire [15:0] crit_release = critical_temp_limit - hyst;
  wire below_rel   = $signed(temp_held) < $signed(crit_release);

  // Register read mux for the sensor pointer
  reg [15:0] ptr_word;
  always @* begin
    case (pointer)
      `SPTSB_PTR_CONFIG: ptr_word = {8'h00, alarm_cfg};
      `SPTSB_PTR_UPPER:  ptr_word = upper_lim;
      `SPTSB_PTR_LOWER:  ptr_word = lower_lim;
      `SPTSB_PTR_CRIT:   ptr_word = critical_temp_limit;
      `SPTSB_PTR_TEMP:   ptr_word = temp_held;
      default:           ptr_word = 16'h0000;
    endcase
  end

  // Address decode of the select byte (bits 7..1 of shreg)
  wire [3:0] rx_type  = shreg[7:4];
  wire       sel_ok   = (shreg[3:1] == sel_pins);
  wire       hv_cmd   = high_voltage_level & (shreg[3] == 1'b0);
  wire       type_ok  = (rx_type == `SPTSB_TYPE_TEMP) | (rx_type == `SPTSB_TYPE_MEM) |
                        (rx_type == `SPTSB_TYPE_LOCK);
  wire       addr_hit = type_ok & (sel_ok | ((rx_type == `SPTSB_TYPE_LOCK) & hv_cmd));

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_in;
      sda_d <= sda_in;
    end
  end

  // Bus protocol engine
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      ret_state <= ST_IDLE;
      shreg     <= 8'h00;
      bitcnt    <= 4'h0;
      bytecnt   <= 2'd0;
      dtype     <= 4'h0;
      is_read   <= 1'b0;
      pointer   <= 8'h00;
      drive_low <= 1'b0;
      tx_word   <= 16'h0000;
      wr_hi     <= 8'h00;
      lock_reversible <= 1'b0;
      lock_permanent  <= 1'b0;
      mem_selected    <= 1'b0;
      alarm_cfg <= `SPTSB_CFG_RESET;
      upper_lim <= `SPTSB_LIM_RESET;
      lower_lim <= `SPTSB_LIM_RESET;
      critical_temp_limit <= `SPTSB_LIM_RESET;
      clear_req <= 1'b0;
    end else begin
      clear_req <= 1'b0;
      if (start_c) begin
        state     <= ST_ADDR;
        bitcnt    <= 4'h0;
        bytecnt   <= 2'd0;
        drive_low <= 1'b0;
      end else if (stop_c) begin
        state        <= ST_IDLE;
        drive_low    <= 1'b0;
        mem_selected <= 1'b0;
      end else begin
        case (state)
          ST_ADDR, ST_WR: begin
            if (scl_rise) begin
              shreg  <= {shreg[6:0], sda_in};
              bitcnt <= bitcnt + 4'h1;
            end
            if (scl_fall && bitcnt == 4'd8) begin
              bitcnt <= 4'h0;
              if (state == ST_ADDR) begin
                if (addr_hit) begin
                  drive_low <= 1'b1;
                  dtype     <= rx_type;
                  is_read   <= shreg[0];
                  mem_selected <= (rx_type == `SPTSB_TYPE_MEM);
                  tx_word   <= ptr_word;
                  ret_state <= shreg[0] ? ST_RD : ST_WR;
                  state     <= ST_ACK;
                  if (rx_type == `SPTSB_TYPE_LOCK && !shreg[0]) begin
                    if (hv_cmd && !lock_permanent)
                      lock_reversible <= ~shreg[2];
                    else if (!hv_cmd)
                      lock_permanent <= 1'b1;
                  end
                end else begin
                  mem_selected <= 1'b0;
                  state        <= ST_SKIP;
                end
              end else begin
                drive_low <= 1'b1;
                state     <= ST_ACK;
                ret_state <= ST_WR;
                bytecnt   <= bytecnt + 2'd1;
                if (dtype == `SPTSB_TYPE_TEMP) begin
                  if (bytecnt == 2'd0)
                    pointer <= shreg;
                  else if (bytecnt == 2'd1)
                    wr_hi <= shreg;
                  else if (bytecnt == 2'd2) begin
                    case (pointer)
                      `SPTSB_PTR_CONFIG: begin
                        alarm_cfg <= shreg & ~(8'h01 << `SPTSB_CFG_CLEAR);
                        clear_req <= shreg[`SPTSB_CFG_CLEAR];
                      end
                      `SPTSB_PTR_UPPER: upper_lim <= {wr_hi, shreg};
                      `SPTSB_PTR_LOWER: lower_lim <= {wr_hi, shreg};
                      `SPTSB_PTR_CRIT:  critical_temp_limit <= {wr_hi, shreg};
                      default: ;
                    endcase
                  end
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              drive_low <= 1'b0;
              state     <= ret_state;
              if (ret_state == ST_RD) begin
                drive_low <= ~tx_word[15];
                tx_word   <= {tx_word[14:0], 1'b0};
                bitcnt    <= 4'h1;
              end
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              if (bitcnt == 4'd8) begin
                drive_low <= 1'b0;
                state     <= ST_MACK;
              end else begin
                drive_low <= ~tx_word[15];
                tx_word   <= {tx_word[14:0], 1'b0};
                bitcnt    <= bitcnt + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise)
              state <= sda_in ? ST_SKIP : ST_ACK;
            if (scl_rise)
              ret_state <= ST_RD;
          end
          ST_SKIP: drive_low <= 1'b0;
          default: state <= ST_IDLE;
        endcase
      end
      if (apb_acc && pwrite) begin
        case (paddr)
          `SPTSB_OFF_CONFIG: begin
            alarm_cfg <= pwdata[7:0] & ~(8'h01 << `SPTSB_CFG_CLEAR);
            clear_req <= pwdata[`SPTSB_CFG_CLEAR];
          end
          `SPTSB_OFF_UPPER: upper_lim <= pwdata[15:0];
          `SPTSB_OFF_LOWER: lower_lim <= pwdata[15:0];
          `SPTSB_OFF_CRIT:  critical_temp_limit <= pwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_cnt <= 32'h0000_0000;
      temp_held  <= 16'h0000;
    end else if (sample_cnt >= SAMPLE_CYC - 32'h0000_0001) begin
      sample_cnt <= 32'h0000_0000;
      if (state != ST_RD)
        temp_held <= temp_sample;
    end else begin
      sample_cnt <= sample_cnt + 32'h0000_0001;
    end
  end

  always @* begin
    if (!alarm_cfg[`SPTSB_CFG_ENABLE])
      next_alarm = 1'b0;
    else if (alarm_cfg[`SPTSB_CFG_CRIT_ONLY])
      next_alarm = crit_hold;
    else if (alarm_cfg[`SPTSB_CFG_COMP])
      next_alarm = above_upper | below_lower | above_crit;
    else
      next_alarm = event_latched | above_crit;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      event_latched <= 1'b0;
      crit_hold     <= 1'b0;
      alarm_out     <= 1'b0;
      alarm_oe      <= 1'b0;
      sda_out       <= 1'b0;
      sda_oe        <= 1'b0;
      scl_oe        <= 1'b0;
    end else begin
      // set wins over clear
      // A clear only sticks once the temperature is back in range
      if (alarm_cfg[`SPTSB_CFG_ENABLE] && (above_upper || below_lower))
        event_latched <= 1'b1;
      else if (clear_req)
        event_latched <= 1'b0;
      if (above_crit)
        crit_hold <= 1'b1;
      else if (below_rel)
        crit_hold <= 1'b0;
      // active high rests at zero (pin pulled low by drive)
      alarm_oe  <= alarm_cfg[`SPTSB_CFG_POL_HIGH] ? ~next_alarm : next_alarm;
      alarm_out <= 1'b0;
      sda_out   <= 1'b0;
      sda_oe    <= drive_low;
      scl_oe    <= 1'b0;
    end
  end

  // APB slave, answers in the access cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h0000_0000;
        case (paddr)
          `SPTSB_OFF_CONFIG: prdata <= {24'h00_0000, alarm_cfg};
          `SPTSB_OFF_UPPER:  prdata <= {16'h0000, upper_lim};
          `SPTSB_OFF_LOWER:  prdata <= {16'h0000, lower_lim};
          `SPTSB_OFF_CRIT:   prdata <= {16'h0000, critical_temp_limit};
          `SPTSB_OFF_TEMP:   prdata <= {16'h0000, temp_held};
          `SPTSB_OFF_STATUS: prdata <= {29'h0000_0000, crit_hold, event_latched, next_alarm};
          `SPTSB_OFF_LOCK:   prdata <= {30'h0000_0000, lock_permanent, lock_reversible};
          default:           pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule // sptsb_slave

// File: common/sptsb_map.vh
// Constants for the two-wire slave with thermal sensor and lock control
`ifndef SPTSB_MAP_VH
`define SPTSB_MAP_VH
// Device type codes
`define SPTSB_TYPE_MEM      4'ha
`define SPTSB_TYPE_LOCK     4'h6
`define SPTSB_TYPE_TEMP     4'h3
// APB register byte offsets
`define SPTSB_OFF_CONFIG    12'h000
`define SPTSB_OFF_UPPER     12'h004
`define SPTSB_OFF_LOWER     12'h008
`define SPTSB_OFF_CRIT      12'h00c
`define SPTSB_OFF_TEMP      12'h010
`define SPTSB_OFF_STATUS    12'h014
`define SPTSB_OFF_LOCK      12'h018
// Config field positions
`define SPTSB_CFG_ENABLE    0
`define SPTSB_CFG_COMP      1
`define SPTSB_CFG_POL_HIGH  2
`define SPTSB_CFG_CRIT_ONLY 3
`define SPTSB_CFG_CLEAR     5
`define SPTSB_CFG_HYST_LO   6
`define SPTSB_CFG_HYST_HI   7
`define SPTSB_CFG_RESET     8'h00
// Sensor pointer values
`define SPTSB_PTR_CONFIG    8'h01
`define SPTSB_PTR_UPPER     8'h02
`define SPTSB_PTR_LOWER     8'h03
`define SPTSB_PTR_CRIT      8'h04
`define SPTSB_PTR_TEMP      8'h05
// Limits reset values
`define SPTSB_LIM_RESET     16'h0000
// Sample interval: 100 ms at 50 MHz
`define SPTSB_SAMPLE_MS     100
`define SPTSB_CLK_KHZ       50000
`define SPTSB_SAMPLE_CYC    (`SPTSB_SAMPLE_MS * `SPTSB_CLK_KHZ)
// Hysteresis in sixteenths of a degree, four steps
`define SPTSB_HYST_0        16'h0000
`define SPTSB_HYST_1        16'h0018
`define SPTSB_HYST_2        16'h0030
`define SPTSB_HYST_3        16'h0060
`endif

// File: tb/sptsb_slave_assertions.sv
// Port-level checks on the two-wire slave
module sptsb_slave_assertions (
  input logic clk,       // System clock
  input logic rst_n,     // Reset, active low
  input logic scl_in,    // Bus clock level
  input logic sda_out,   // Data drive value
  input logic sda_oe,    // Data pull enable
  input logic scl_oe,    // Clock drive enable
  input logic alarm_out, // Alarm drive value
  input logic alarm_oe,  // Alarm pull enable
  input logic psel,      // APB select
  input logic penable,   // APB enable
  input logic pready,    // APB ready
  input logic pslverr    // APB error
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  scl_never_driven_a: assert property (!scl_oe)
    else $error("clock line driven");
  sda_open_drain_a: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  alarm_open_drain_a: assert property (alarm_out == 1'b0)
    else $error("alarm line driven high");
  apb_no_wait_a: assert property (psel && !penable |=> pready)
    else $error("ready missing in access cycle");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  error_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  ack_moves_low_a: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("data drive moved near clock rise");
  data_steady_high_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("data drive moved while clock high");
  cover property (pslverr);
  cover property ($rose(sda_oe));
  cover property ($rose(alarm_oe));
endmodule // sptsb_slave_assertions

bind sptsb_slave sptsb_slave_assertions i_chk (.clk(clk), .rst_n(rst_n), .scl_in(scl_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .scl_oe(scl_oe), .alarm_out(alarm_out),
  .alarm_oe(alarm_oe), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr));

// File: tb/sptsb_i2c_master.sv
// Behavioural two-wire bus master facing the slave
module sptsb_i2c_master #(
  parameter int Q = 10   // Clock cycles per quarter bit
) (
  input  logic clk,      // System clock
  input  logic sda,      // Resolved data line
  output logic scl,      // Serial clock, push-pull, high when idle
  output logic sda_low   // High while pulling data low
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic qwait();
    repeat (Q) @(posedge clk);
  endtask
  task automatic start();
    sda_low <= 1'b0;
    qwait();
    scl <= 1'b1;
    qwait();
    sda_low <= 1'b1;
    qwait();
    scl <= 1'b0;
    qwait();
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    qwait();
    scl <= 1'b1;
    qwait();
    sda_low <= 1'b0;
    qwait();
  endtask
  // Data only moves while the clock is low
  task automatic tx_bit(input logic v, output logic s);
    sda_low <= !v;
    qwait();
    scl <= 1'b1;
    qwait();
    s = sda;
    qwait();
    scl <= 1'b0;
    qwait();
  endtask
  // direction is the last select bit, sent MSB first
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) tx_bit(b[i], s);
    tx_bit(1'b1, s);
    ack = !s;
  endtask
  // master acks high byte, refuses the last
  task automatic rbyte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) tx_bit(1'b1, b[i]);
    tx_bit(nack, s);
  endtask
endmodule // sptsb_i2c_master

// File: tb/tb.sv
// Self-checking bench for the two-wire slave
`include "sptsb_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, hv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        scl, m_low, sda_oe, sda_out, scl_oe, alarm_out, alarm_oe;
  logic        lock_rev, lock_perm, mem_sel;
  logic [2:0]  pins;
  logic [15:0] temp;
  int          bad_count = 0;
  int          num_checks = 0;
  wire         sda = !(m_low || sda_oe);
  always #10 clk = ~clk;
  sptsb_slave #(.SAMPLE_CYC(32'd100)) i_dut (.clk(clk), .rst_n(rst_n), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .scl_oe(scl_oe),
    .addr_select_bit0(pins[0]), .addr_select_bit1(pins[1]), .addr_select_bit2(pins[2]),
    .high_voltage_level(hv), .temp_sample(temp), .alarm_out(alarm_out), .alarm_oe(alarm_oe),
    .lock_reversible(lock_rev), .lock_permanent(lock_perm), .mem_selected(mem_sel),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  sptsb_i2c_master i_mst (.clk(clk), .sda(sda), .scl(scl), .sda_low(m_low));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d errors=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk(e, 0);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 0, r, e);
    chk(r, exp);
  endtask
  function automatic logic [7:0] sel(input logic [3:0] t, input logic rw);
    return {t, pins, rw};
  endfunction
  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic a;
    i_mst.wbyte(b, a);
    chk(a, exp_ack);
  endtask
  task automatic sensor_rd(input logic [7:0] p, output logic [15:0] v);
    i_mst.start();
    send(sel(4'h3, 1'b0), 1'b1);
    send(p, 1'b1);
    i_mst.start();
    send(sel(4'h3, 1'b1), 1'b1);
    i_mst.rbyte(1'b0, v[15:8]);
    i_mst.rbyte(1'b1, v[7:0]);
    i_mst.stop();
  endtask
  // Two and a half sample periods so the new level is seen for sure
  task automatic settle(input logic [15:0] t);
    temp <= t;
    repeat (250) @(posedge clk);
  endtask
  initial begin
    logic [15:0] v, rv;
    logic [31:0] r;
    logic        e;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    hv = 1'b0;
    temp = 16'h0100;
    void'($urandom(83));
    pins = 3'($urandom);
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_chk(`SPTSB_OFF_CONFIG, 32'h0000_0000);
    rd_chk(`SPTSB_OFF_UPPER, 32'h0000_0000);
    apb(1'b0, 12'h01c, 0, r, e);
    chk(e, 1);
    v = 16'($urandom);
    i_mst.start();
    send(sel(4'h3, 1'b0), 1'b1);
    send(`SPTSB_PTR_UPPER, 1'b1);
    send(v[15:8], 1'b1);
    send(v[7:0], 1'b1);
    i_mst.stop();
    rd_chk(`SPTSB_OFF_UPPER, {16'h0000, v});
    v = 16'($urandom);
    settle(v);
    sensor_rd(`SPTSB_PTR_TEMP, rv);
    chk(rv, v);
    rd_chk(`SPTSB_OFF_TEMP, {16'h0000, v});
    for (int k = 1; k < 8; k++) begin
      i_mst.start();
      send({4'h3, pins ^ 3'(k), 1'b0}, 1'b0);
      i_mst.stop();
    end
    // Lock type is left out here: a plain select would lock for good
    for (int t = 0; t < 16; t++) begin
      if (t != 6) begin
        i_mst.start();
        send({4'(t), pins, 1'b0}, t == 3 || t == 10);
        chk(mem_sel, t == 10);
        i_mst.stop();
      end
    end
    hv <= 1'b1;
    i_mst.start();
    send(8'h62, 1'b1);
    i_mst.stop();
    chk({lock_rev, lock_perm}, 2'b10);
    i_mst.start();
    send(8'h66, 1'b1);
    i_mst.stop();
    chk({lock_rev, lock_perm}, 2'b00);
    hv <= 1'b0;
    wr(`SPTSB_OFF_CRIT, 32'h0000_0800);
    wr(`SPTSB_OFF_UPPER, 32'h0000_0400);
    wr(`SPTSB_OFF_LOWER, 32'h0000_0000);
    wr(`SPTSB_OFF_CONFIG, 32'h0000_0003);
    settle(16'h0500);
    chk(alarm_oe, 1);
    settle(16'h0200);
    chk(alarm_oe, 0);
    wr(`SPTSB_OFF_CONFIG, 32'h0000_0021);
    settle(16'h0200);
    chk(alarm_oe, 0);
    settle(16'h0500);
    chk(alarm_oe, 1);
    settle(16'h0200);
    chk(alarm_oe, 1);
    wr(`SPTSB_OFF_CONFIG, 32'h0000_0021);
    settle(16'h0200);
    chk(alarm_oe, 0);
    wr(`SPTSB_OFF_UPPER, 32'h0000_0a00);
    settle(16'h0900);
    chk(alarm_oe, 1);
    settle(16'h0200);
    chk(alarm_oe, 0);
    wr(`SPTSB_OFF_UPPER, 32'h0000_0400);
    wr(`SPTSB_OFF_CONFIG, 32'h0000_00c9);
    settle(16'h0500);
    chk(alarm_oe, 0);
    settle(16'h0900);
    chk(alarm_oe, 1);
    settle(16'h07f0);
    chk(alarm_oe, 1);
    settle(16'h0700);
    chk(alarm_oe, 0);
    wr(`SPTSB_OFF_CONFIG, 32'h0000_0007);
    settle(16'h0200);
    chk(alarm_oe, 1);
    settle(16'h0500);
    chk(alarm_oe, 0);
    complete_run();
  end
  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    complete_run();
  end
endmodule // tb
